// ---- cfg_id_pkg.sv ----
// Package: constants, register map and carriers of the identification block
package cfg_id_pkg;

    // ****************************************************************
    // Register offsets (byte addresses of configuration space)
    // ****************************************************************
    localparam logic [11:0] OFS_ID_WORD    = 12'h000;
    localparam logic [11:0] OFS_CLASS_WORD = 12'h008;
    localparam logic [11:0] OFS_BOARD_WORD = 12'h02C;
    localparam logic [11:0] OFS_FUNC_CAP   = 12'h084;
    localparam logic [11:0] OFS_FUNC_CAP2  = 12'h0A4;
    localparam logic [11:0] OFS_FUNC_CTL2  = 12'h0A8;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int POS_FUNC_ID      = 16;
    localparam int POS_CLASS        = 8;
    localparam int POS_BOARD_FUNC   = 16;
    localparam int POS_CTL2_DISABLE = 4;
    localparam int FORBIDDEN_VENDOR_W = 16;
    localparam logic [15:0] FORBIDDEN_VENDOR = 16'hFFFF;

    // ****************************************************************
    // Reset values (identification values are arbitrary)
    // ****************************************************************
    localparam logic [15:0] RST_MAKER       = 16'h1AB4;
    localparam logic [15:0] RST_FUNCTION    = 16'h5C21;
    localparam logic [7:0]  RST_REVISION    = 8'h3E;
    localparam logic [23:0] RST_CLASS       = 24'h0B4200;
    localparam logic [15:0] RST_BOARD_MAKER = 16'h2D17;
    localparam logic [15:0] RST_BOARD_FUNC  = 16'h6A09;
    localparam logic [2:0]  PAYLOAD_128     = 3'h0;
    localparam logic [2:0]  PAYLOAD_256     = 3'h1;
    localparam logic [3:0]  RANGES_ALL      = 4'hF;
    localparam logic [3:0]  CTO_DEFAULT_ENC = 4'h0;

    // ****************************************************************
    // Timing: completion timeout limits in microseconds
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_NS       = 1000;
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    localparam logic [25:0] CTO_DEF_US = 26'h000C350;  // 50 ms
    localparam logic [25:0] CTO_A_LO_US = 26'h0000032; // 50 us
    localparam logic [25:0] CTO_A_HI_US = 26'h0002710; // 10 ms
    localparam logic [25:0] CTO_B_HI_US = 26'h003D090; // 250 ms
    localparam logic [25:0] CTO_C_HI_US = 26'h03D0900; // 4 s
    localparam logic [25:0] CTO_D_HI_US = 26'h3D09000; // 64 s

    // ****************************************************************
    // Enumerations and carriers
    // ****************************************************************
    typedef enum logic [1:0] {
        FUNC_ENDPOINT  = 2'b00,
        FUNC_ROOT_PORT = 2'b01,
        FUNC_OTHER     = 2'b10
    } func_kind_t;

    typedef enum logic [2:0] {
        SEL_MAKER       = 3'h0,
        SEL_FUNCTION    = 3'h1,
        SEL_REVISION    = 3'h2,
        SEL_CLASS       = 3'h3,
        SEL_BOARD_MAKER = 3'h4,
        SEL_BOARD_FUNC  = 3'h5,
        SEL_PAYLOAD     = 3'h6
    } rcfg_sel_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic      valid;
        rcfg_sel_t sel;
        logic [23:0] data;
    } rcfg_req_t;

    typedef struct packed {
        logic [15:0] maker;
        logic [15:0] function_id;
        logic [7:0]  revision;
        logic [23:0] class_code;
        logic [15:0] board_maker;
        logic [15:0] board_function;
        logic [2:0]  payload;
    } id_regs_t;

endpackage : cfg_id_pkg

// ---- tick_divider.sv ----
// Divider that makes a one-cycle enable pulse every CYCLES clocks
`timescale 1ns/10ps
`default_nettype none

module tick_divider #(
    parameter int CYCLES = 250
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic run_i,
    output logic      tick_o
);

    typedef struct packed {
        logic [15:0] count;
        logic        tick;
    } div_state_t;

    localparam logic [15:0] LAST = 16'(CYCLES - 1);

    div_state_t state;
    div_state_t next_state;

    always_comb
    begin
        next_state      = state;
        next_state.tick = 1'b0;
        if (!run_i)
        begin
            next_state.count = 16'h0000;
        end
        else if (state.count == LAST)
        begin
            next_state.count = 16'h0000;
            next_state.tick  = 1'b1;
        end
        else
        begin
            next_state.count = state.count + 16'h0001;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign tick_o = state.tick;

endmodule : tick_divider

`default_nettype wire

// ---- cto_limit.sv ----
// Decoder from completion timeout encoding to a limit in microseconds
`timescale 1ns/10ps
`default_nettype none

module cto_limit (
    input  wire logic [3:0]  enc_i,
    input  wire logic [3:0]  ranges_i,
    output logic      [25:0] limit_us_o
);

    logic       supported;
    logic [1:0] group;

    always_comb
    begin
        group      = enc_i[3:2];
        supported  = ranges_i[group] &&
                     (enc_i[1:0] == 2'b01 || enc_i[1:0] == 2'b10);
        limit_us_o = cfg_id_pkg::CTO_DEF_US;
        if (supported)
        begin
            case (enc_i)
                4'h1:    limit_us_o = cfg_id_pkg::CTO_A_LO_US;
                4'h2:    limit_us_o = cfg_id_pkg::CTO_A_HI_US;
                4'h5:    limit_us_o = cfg_id_pkg::CTO_A_HI_US;
                4'h6:    limit_us_o = cfg_id_pkg::CTO_B_HI_US;
                4'h9:    limit_us_o = cfg_id_pkg::CTO_B_HI_US;
                4'hA:    limit_us_o = cfg_id_pkg::CTO_C_HI_US;
                4'hD:    limit_us_o = cfg_id_pkg::CTO_C_HI_US;
                4'hE:    limit_us_o = cfg_id_pkg::CTO_D_HI_US;
                default: limit_us_o = cfg_id_pkg::CTO_DEF_US;
            endcase
        end
    end

endmodule : cto_limit

`default_nettype wire

// ---- pcie_config_id_and_caps.sv ----
// Identification and capability registers of one configuration function
//
// Behaviour
// [R1] Maker identifier, 16 bits, read-only at 0x000 low half.
// [R2] Maker identifier value 0xFFFF is refused; old value kept.
// [R3] Function identifier, 16 bits, read-only at 0x000 high half.
// [R4] Silicon revision, 8 bits, read-only at 0x008 low byte.
// [R5] Function class, 24 bits, read-only at 0x008 upper bytes.
// [R6] Board maker identifier at 0x02C, read-only, never 0xFFFF.
// [R7] Board maker identifier exists only for type 0 endpoints.
// [R8] Board function identifier at 0x02C only for type 0 endpoints.
// [R9] Reconfiguration port replaces identifiers; link side stays read-only.
// [R10] Max payload 128 or 256, default 128, read-only at 0x084[2:0].
// [R11] Timeout ranges advertised only for root ports, requesting endpoints.
// [R12] Selected timeout and disable taken from control register 0x0A8.
// [R13] Ranges A 50us-10ms, B 10ms-250ms, C 250ms-4s supported.
// [R14] Range D spans 4 s to 64 s.
// [R15] Range field patterns: 0001 A, 0011 A+B, 1111 all four.
// [R16] Link writes to identification and capability fields are ignored.
`timescale 1ns/10ps
`default_nettype none

module pcie_config_id_and_caps #(
    parameter cfg_id_pkg::func_kind_t FUNC_KIND = cfg_id_pkg::FUNC_ENDPOINT,
    parameter logic       ISSUES_REQUESTS = 1'b1,
    parameter logic       PAYLOAD_IS_256  = 1'b0,
    parameter logic [3:0] CTO_RANGES      = cfg_id_pkg::RANGES_ALL,
    parameter int         TICK_CYCLES     = cfg_id_pkg::TICK_CYCLES
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire cfg_id_pkg::cfg_req_t  cfg_req_i,
    output logic                       cfg_ack_o,
    output logic                [31:0] cfg_rdata_o,
    input  wire cfg_id_pkg::rcfg_req_t rcfg_req_i,
    output logic                       rcfg_reject_o,
    input  wire logic                  cpl_pending_i,
    output logic                       cpl_timeout_o
);

    // ****************************************************************
    // Types and state
    // ****************************************************************
    typedef enum logic [1:0] {
        TMR_IDLE    = 2'b00,
        TMR_COUNT   = 2'b01,
        TMR_EXPIRED = 2'b10
    } tmr_state_t;

    typedef struct packed {
        cfg_id_pkg::id_regs_t ids;
        logic [3:0]           ctl2_value;
        logic                 ctl2_disable;
        logic                 ack;
        logic [31:0]          rdata;
        logic                 reject;
        tmr_state_t           tmr;
        logic [25:0]          us_count;
        logic                 timeout;
    } state_t;

    state_t state;
    state_t next_state;

    logic        type0_endpoint;
    logic        ranges_allowed;
    logic [3:0]  ranges_field;
    logic [2:0]  payload_default;
    logic [25:0] limit_us;
    logic        tick;
    logic        timer_run;
    logic [9:0]  word_addr;
    logic        ctl2_hit;
    logic        payload_init_done;

    // ****************************************************************
    // Static configuration decode, access address decode and timer run
    // ****************************************************************
    assign type0_endpoint = (FUNC_KIND == cfg_id_pkg::FUNC_ENDPOINT); // [R7]
    assign ranges_allowed = (FUNC_KIND == cfg_id_pkg::FUNC_ROOT_PORT) ||
                            (type0_endpoint && ISSUES_REQUESTS); // [R11]
    assign ranges_field   = ranges_allowed ? CTO_RANGES : 4'h0; // [R11] [R15]
    assign payload_default = PAYLOAD_IS_256 ? cfg_id_pkg::PAYLOAD_256
                                            : cfg_id_pkg::PAYLOAD_128; // [R10]
    assign word_addr      = cfg_req_i.addr[11:2];
    assign ctl2_hit       = (word_addr == cfg_id_pkg::OFS_FUNC_CTL2[11:2]);
    assign timer_run      = (state.tmr == TMR_COUNT);

    // ****************************************************************
    // Timebase and timeout limit
    // ****************************************************************
    tick_divider #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .run_i   (timer_run),
        .tick_o  (tick)
    );

    cto_limit u_limit (
        .enc_i      (state.ctl2_value), // [R12]
        .ranges_i   (ranges_field),     // [R13] [R14]
        .limit_us_o (limit_us)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        next_state         = state;
        next_state.ack     = 1'b0;
        next_state.reject  = 1'b0;
        next_state.timeout = 1'b0;

        // Reconfiguration port writes
        if (rcfg_req_i.valid) // [R9]
        begin
            case (rcfg_req_i.sel)
                cfg_id_pkg::SEL_MAKER:
                begin
                    if (rcfg_req_i.data[15:0] ==
                        cfg_id_pkg::FORBIDDEN_VENDOR) // [R2]
                    begin
                        next_state.reject = 1'b1;
                    end
                    else
                    begin
                        next_state.ids.maker = rcfg_req_i.data[15:0]; // [R1]
                    end
                end
                cfg_id_pkg::SEL_FUNCTION:
                begin
                    next_state.ids.function_id = rcfg_req_i.data[15:0]; // [R3]
                end
                cfg_id_pkg::SEL_REVISION:
                begin
                    next_state.ids.revision = rcfg_req_i.data[7:0]; // [R4]
                end
                cfg_id_pkg::SEL_CLASS:
                begin
                    next_state.ids.class_code = rcfg_req_i.data; // [R5]
                end
                cfg_id_pkg::SEL_BOARD_MAKER:
                begin
                    if (rcfg_req_i.data[15:0] ==
                        cfg_id_pkg::FORBIDDEN_VENDOR) // [R6]
                    begin
                        next_state.reject = 1'b1;
                    end
                    else
                    begin
                        next_state.ids.board_maker = rcfg_req_i.data[15:0];
                    end
                end
                cfg_id_pkg::SEL_BOARD_FUNC:
                begin
                    next_state.ids.board_function = rcfg_req_i.data[15:0];
                end
                cfg_id_pkg::SEL_PAYLOAD:
                begin
                    if (rcfg_req_i.data[2:0] == cfg_id_pkg::PAYLOAD_128 ||
                        rcfg_req_i.data[2:0] == cfg_id_pkg::PAYLOAD_256)
                    begin
                        next_state.ids.payload = rcfg_req_i.data[2:0]; // [R10]
                    end
                    else
                    begin
                        next_state.reject = 1'b1;
                    end
                end
                default:
                begin
                    next_state.reject = 1'b1;
                end
            endcase
        end

        // Configuration accesses from the link
        if (cfg_req_i.valid)
        begin
            next_state.ack   = 1'b1;
            next_state.rdata = 32'h0000_0000;
            if (cfg_req_i.write)
            begin
                // Only the timeout control register accepts writes
                if (ctl2_hit && cfg_req_i.be[0]) // [R12] [R16]
                begin
                    if (ranges_allowed)
                    begin
                        next_state.ctl2_value = cfg_req_i.wdata[3:0];
                    end
                    next_state.ctl2_disable =
                        cfg_req_i.wdata[cfg_id_pkg::POS_CTL2_DISABLE];
                end
            end
            else
            begin
                case (word_addr)
                    cfg_id_pkg::OFS_ID_WORD[11:2]:
                    begin
                        next_state.rdata = {state.ids.function_id,
                                            state.ids.maker}; // [R1] [R3]
                    end
                    cfg_id_pkg::OFS_CLASS_WORD[11:2]:
                    begin
                        next_state.rdata = {state.ids.class_code,
                                            state.ids.revision}; // [R4] [R5]
                    end
                    cfg_id_pkg::OFS_BOARD_WORD[11:2]:
                    begin
                        if (type0_endpoint) // [R7] [R8]
                        begin
                            next_state.rdata = {state.ids.board_function,
                                                state.ids.board_maker};
                        end
                    end
                    cfg_id_pkg::OFS_FUNC_CAP[11:2]:
                    begin
                        next_state.rdata = {29'h0000_0000,
                                            state.ids.payload}; // [R10]
                    end
                    cfg_id_pkg::OFS_FUNC_CAP2[11:2]:
                    begin
                        next_state.rdata = {28'h000_0000,
                                            ranges_field}; // [R11]
                    end
                    cfg_id_pkg::OFS_FUNC_CTL2[11:2]:
                    begin
                        next_state.rdata = {27'h000_0000,
                                            state.ctl2_disable,
                                            state.ctl2_value};
                    end
                    default:
                    begin
                        next_state.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end

        // Completion timeout timer
        case (state.tmr)
            TMR_IDLE:
            begin
                next_state.us_count = 26'h000_0000;
                if (cpl_pending_i && !state.ctl2_disable) // [R12]
                begin
                    next_state.tmr = TMR_COUNT;
                end
            end
            TMR_COUNT:
            begin
                if (!cpl_pending_i || state.ctl2_disable)
                begin
                    next_state.tmr = TMR_IDLE;
                end
                else if (tick)
                begin
                    if (state.us_count + 26'h000_0001 >= limit_us) // [R13]
                    begin
                        next_state.tmr     = TMR_EXPIRED;
                        next_state.timeout = 1'b1;
                    end
                    else
                    begin
                        next_state.us_count = state.us_count + 26'h000_0001;
                    end
                end
            end
            TMR_EXPIRED:
            begin
                if (!cpl_pending_i)
                begin
                    next_state.tmr = TMR_IDLE;
                end
            end
            default:
            begin
                next_state.tmr = TMR_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state                    <= '0;
            state.ids.maker          <= cfg_id_pkg::RST_MAKER;
            state.ids.function_id    <= cfg_id_pkg::RST_FUNCTION;
            state.ids.revision       <= cfg_id_pkg::RST_REVISION;
            state.ids.class_code     <= cfg_id_pkg::RST_CLASS;
            state.ids.board_maker    <= cfg_id_pkg::RST_BOARD_MAKER;
            state.ids.board_function <= cfg_id_pkg::RST_BOARD_FUNC;
            state.ids.payload        <= cfg_id_pkg::PAYLOAD_128;
            state.ctl2_value         <= cfg_id_pkg::CTO_DEFAULT_ENC;
            state.tmr                <= TMR_IDLE;
        end
        else
        begin
            state <= next_state;
            // Build-time payload choice reloads once at release
            if (!payload_init_done)
            begin
                state.ids.payload <= payload_default;
            end
        end
    end

    // ****************************************************************
    // Payload parameter load after reset release
    // ****************************************************************

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            payload_init_done <= 1'b0;
        end
        else
        begin
            payload_init_done <= 1'b1;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign cfg_ack_o     = state.ack;
    assign cfg_rdata_o   = state.rdata;
    assign rcfg_reject_o = state.reject;
    assign cpl_timeout_o = state.timeout;

endmodule : pcie_config_id_and_caps

`default_nettype wire

// ---- cfg_id_props.sv ----
// Checker: port assertions of the identification block
`timescale 1ns/10ps
`default_nettype none

module cfg_id_props (
    input wire logic                  clk_i,
    input wire logic                  rst_n_i,
    input wire cfg_id_pkg::cfg_req_t  cfg_req_i,
    input wire logic                  cfg_ack_o,
    input wire logic           [31:0] cfg_rdata_o,
    input wire cfg_id_pkg::rcfg_req_t rcfg_req_i,
    input wire logic                  rcfg_reject_o,
    input wire logic                  cpl_pending_i,
    input wire logic                  cpl_timeout_o
);
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking dck @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    logic ff_data;
    logic bad_maker;
    logic bad_board;
    logic rd_cap;
    assign ff_data   = rcfg_req_i.valid && rcfg_req_i.data[15:0] == 16'hFFFF;
    assign bad_maker = ff_data && rcfg_req_i.sel == cfg_id_pkg::SEL_MAKER;
    assign bad_board = ff_data && rcfg_req_i.sel == cfg_id_pkg::SEL_BOARD_MAKER;
    assign rd_cap    = cfg_req_i.valid && !cfg_req_i.write
                       && cfg_req_i.addr[11:2] == 10'h021;

    AST_ACK: assert property (cfg_req_i.valid |=> cfg_ack_o)
        else $error("access not acknowledged");
    AST_NO_ACK: assert property (!cfg_req_i.valid |=> !cfg_ack_o)
        else $error("ack without access");
    AST_WR_ZERO: assert property (cfg_req_i.valid
        && cfg_req_i.write |=> cfg_rdata_o == 32'h0)
        else $error("write returned data");
    AST_HOLD: assert property (!cfg_req_i.valid
        |=> $stable(cfg_rdata_o))
        else $error("read data changed without access");
    AST_REJ_MAKER: assert property (bad_maker |=> rcfg_reject_o)
        else $error("all-ones maker value taken");
    AST_REJ_BOARD: assert property (bad_board |=> rcfg_reject_o)
        else $error("all-ones board maker value taken");
    AST_REJ_CAUSE: assert property (rcfg_reject_o
        |-> $past(rcfg_req_i.valid))
        else $error("reject without reconfiguration");
    AST_PAYLOAD: assert property (rd_cap
        |=> cfg_rdata_o[31:1] == 31'h0)
        else $error("payload field out of range");
    AST_CTO_CAUSE: assert property (cpl_timeout_o
        |-> $past(cpl_pending_i, 2))
        else $error("timeout without pending completion");
    AST_CTO_ONCE: assert property (cpl_timeout_o |=> !cpl_timeout_o)
        else $error("timeout pulse longer than one cycle");

    cover property (cpl_timeout_o);
    cover property (rcfg_reject_o);
    cover property (cfg_req_i.valid && cfg_req_i.write);
endmodule : cfg_id_props

bind pcie_config_id_and_caps cfg_id_props u_props (
    .clk_i         (clk_i),
    .rst_n_i       (rst_n_i),
    .cfg_req_i     (cfg_req_i),
    .cfg_ack_o     (cfg_ack_o),
    .cfg_rdata_o   (cfg_rdata_o),
    .rcfg_req_i    (rcfg_req_i),
    .rcfg_reject_o (rcfg_reject_o),
    .cpl_pending_i (cpl_pending_i),
    .cpl_timeout_o (cpl_timeout_o)
);
`default_nettype wire

// ---- link_host_model.sv ----
// Link host model: issues configuration reads and writes
`timescale 1ns/10ps
`default_nettype none

module link_host_model (
    input  wire logic            clk_i,
    input  wire logic            ack_i,
    input  wire logic     [31:0] rdata_i,
    output var cfg_id_pkg::cfg_req_t req_o
);
    // ****************************************************************
    // Access task
    // ****************************************************************
    initial req_o = '0;

    // One access; released fields are inverted so stale values never match
    task access(input logic wr, input logic [11:0] a,
                input logic [31:0] d, output logic [31:0] q);
        @(negedge clk_i);
        req_o = '{valid: 1'b1, write: wr, addr: a, be: 4'hF, wdata: d};
        @(negedge clk_i);
        req_o.valid = 1'b0;
        req_o.addr = ~a;
        req_o.wdata = ~d;
        q = (ack_i === 1'b1) ? rdata_i : 32'hXXXXXXXX;
    endtask : access
endmodule : link_host_model
`default_nettype wire

// ---- testbench.sv ----
// Testbench: register map, reconfiguration and timeout of the block
`timescale 1ns/10ps
`default_nettype none

module testbench;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    localparam int TICK  = 2;
    localparam int LIMIT = 3000;
    logic                  clk = 1'b0;
    logic                  rst_n;
    cfg_id_pkg::cfg_req_t  req;
    logic                  ack;
    logic           [31:0] rdata;
    logic           [31:0] rdata2;
    cfg_id_pkg::rcfg_req_t rcfg;
    logic                  reject;
    logic                  pend;
    logic                  tmo;
    int                    bad_count = 0;
    int                    compares = 0;
    int                    cycles = 0;
    int                    n;
    int                    lim;

    always #2 clk = ~clk;

    pcie_config_id_and_caps #(.TICK_CYCLES(TICK)) dut (
        .clk_i(clk), .rst_n_i(rst_n), .cfg_req_i(req), .cfg_ack_o(ack),
        .cfg_rdata_o(rdata), .rcfg_req_i(rcfg), .rcfg_reject_o(reject),
        .cpl_pending_i(pend), .cpl_timeout_o(tmo));

    link_host_model u_host (.clk_i(clk), .ack_i(ack), .rdata_i(rdata),
                            .req_o(req));

    pcie_config_id_and_caps #(.FUNC_KIND(cfg_id_pkg::FUNC_OTHER)) dut_other (
        .clk_i(clk), .rst_n_i(rst_n), .cfg_req_i(req), .cfg_ack_o(),
        .cfg_rdata_o(rdata2), .rcfg_req_i(rcfg), .rcfg_reject_o(),
        .cpl_pending_i(pend), .cpl_timeout_o());

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task final_report();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        u_host.access(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask : rd

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        u_host.access(1'b1, a, d, q);
        chk(q, 32'h0);
    endtask : wr

    task rc(input logic [2:0] s, input logic [23:0] d, input logic e);
        @(negedge clk);
        rcfg = '{valid: 1'b1, sel: cfg_id_pkg::rcfg_sel_t'(s), data: d};
        @(negedge clk);
        rcfg.valid = 1'b0;
        rcfg.data = ~d;
        chk({31'h0, reject}, {31'h0, e});
    endtask : rc

    task ids(input logic [15:0] m, input logic [2:0] p);
        rd(cfg_id_pkg::OFS_ID_WORD, {cfg_id_pkg::RST_FUNCTION, m});
        rd(cfg_id_pkg::OFS_CLASS_WORD,
           {cfg_id_pkg::RST_CLASS, cfg_id_pkg::RST_REVISION});
        rd(cfg_id_pkg::OFS_BOARD_WORD,
           {cfg_id_pkg::RST_BOARD_FUNC, cfg_id_pkg::RST_BOARD_MAKER});
        rd(cfg_id_pkg::OFS_FUNC_CAP, {29'h0, p});
        rd(cfg_id_pkg::OFS_FUNC_CAP2,
           {28'h0, cfg_id_pkg::RANGES_ALL});
    endtask : ids

    // ****************************************************************
    // Hang guard and main sequence
    // ****************************************************************
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            bad_count++;
            final_report();
        end
    end

    initial
    begin
        rst_n = 1'b0;
        rcfg = '0;
        pend = 1'b0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        ids(cfg_id_pkg::RST_MAKER, cfg_id_pkg::PAYLOAD_128);
        chk(rdata2, 32'h0);
        rd(12'h010, 32'h0);
        wr(12'h000, 32'hFFFFFFFF);
        wr(12'h008, 32'hFFFFFFFF);
        wr(12'h02C, 32'hFFFFFFFF);
        wr(12'h084, 32'hFFFFFFFF);
        ids(cfg_id_pkg::RST_MAKER, cfg_id_pkg::PAYLOAD_128);
        rc(3'h0, 24'h001234, 1'b0);
        rc(3'h0, 24'h00FFFF, 1'b1);
        rc(3'h4, 24'h00FFFF, 1'b1);
        rc(3'h6, 24'h000002, 1'b1);
        rc(3'h6, 24'h000001, 1'b0);
        rc(3'h7, 24'h000000, 1'b1);
        ids(16'h1234, cfg_id_pkg::PAYLOAD_256);
        wr(cfg_id_pkg::OFS_FUNC_CTL2, 32'h00000001);
        rd(cfg_id_pkg::OFS_FUNC_CTL2, 32'h00000001);
        lim = int'(cfg_id_pkg::CTO_A_LO_US) * TICK;
        pend = 1'b1;
        n = 0;
        while (tmo !== 1'b1 && n < lim * 2)
        begin
            @(negedge clk);
            n++;
        end
        chk((n >= lim - 4 && n <= lim + 8) ? 32'h1 : 32'(n), 32'h1);
        pend = 1'b0;
        wr(cfg_id_pkg::OFS_FUNC_CTL2, 32'h00000011);
        rd(cfg_id_pkg::OFS_FUNC_CTL2, 32'h00000011);
        chk(rdata2, 32'h10);
        pend = 1'b1;
        n = 0;
        repeat (lim * 3)
        begin
            @(negedge clk);
            if (tmo !== 1'b0)
                n++;
        end
        chk(32'(n), 32'h0);
        pend = 1'b0;
        final_report();
    end
endmodule : testbench
`default_nettype wire
